// *** inc/dma_chan_defs.svh ***
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL_STATUS 12'h000
`define OFS_DESC_ADDR 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_IRQ_SUMMARY 12'hfe0
`define OFS_CHAN_ENABLES 12'hff0

// ****************************************
// control and status fields
// ****************************************
`define BIT_CHAN_RESET 31
`define BIT_ABANDON 30
`define BIT_IGNORE_HALT 29
`define BIT_DRAIN_WRITES 28
`define URGENT_PRIO_HI 23
`define URGENT_PRIO_LO 20
`define NORMAL_PRIO_HI 19
`define NORMAL_PRIO_LO 16
`define BIT_WAIT_WRITES 6
`define BIT_PAUSED 4
`define BIT_IRQ_PENDING 2
`define BIT_BLOCK_DONE 1
`define BIT_ACTIVE 0
`define CTRL_RW_MASK 32'h30ff0001

// ****************************************
// counts and reset values
// ****************************************
`define MAX_OUTSTANDING 5'h0d
`define ENABLES_RESET 32'h00000001
`define NUM_CHANNELS 32
`define THIS_CHANNEL 0

`endif

// *** inc/dma_chan_pkg.sv ***
package dma_chan_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_RUN = 3'b010,
		ST_DRAIN = 3'b011,
		ST_DONE = 3'b100
	} chan_state_t;
endpackage

// *** test/desc_partner.sv ***
`timescale 1ns/10ps
module desc_partner
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fetch_request,
	input wire logic transfer_go,
	input wire logic [31:0] cfg_next,
	input wire logic cfg_irq,
	input wire logic [5:0] cfg_beats,
	input wire logic cfg_hold,
	output logic fetch_done,
	output logic [31:0] fetch_next_address,
	output logic fetch_irq_on_block_done,
	output logic transfer_last,
	output logic write_issued,
	output logic write_response
);
	logic [1:0] wait_cnt;
	logic slow;
	logic [5:0] beat;
	logic [5:0] len;
	logic [5:0] owed;
	// descriptor words are junk outside fetch_done
	assign fetch_next_address = fetch_done ? cfg_next : ~cfg_next;
	assign fetch_irq_on_block_done = fetch_done ? cfg_irq : ~cfg_irq;
	assign transfer_last = transfer_go && beat == len - 6'h01;
	assign write_issued = transfer_go;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fetch_done <= 1'h0;
			wait_cnt <= 2'h0;
			slow <= 1'h0;
			beat <= 6'h00;
			len <= 6'h01;
			owed <= 6'h00;
			write_response <= 1'h0;
		end
		else
		begin
			fetch_done <= 1'h0;
			if (fetch_request && !fetch_done)
			begin
				wait_cnt <= wait_cnt + 2'h1;
				// fetches alternate between prompt and slow
				if (wait_cnt == (slow ? 2'h2 : 2'h0))
				begin
					fetch_done <= 1'h1;
					wait_cnt <= 2'h0;
					slow <= !slow;
					beat <= 6'h00;
					len <= cfg_beats;
				end
			end
			if (transfer_go)
				beat <= beat + 6'h01;
			// the pulse in flight is already owed, so do not count it twice
			write_response <= !cfg_hold && owed > {5'h00, write_response};
			owed <= owed + {5'h00, write_issued} - {5'h00, write_response};
		end
	end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
`include "dma_chan_defs.svh"
module testbench;
	localparam logic [11:0] CS = `OFS_CTRL_STATUS;
	localparam logic [11:0] DA = `OFS_DESC_ADDR;
	logic clk = 1'h0, rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0, debug_halt = 1'h0, peripheral_urgent = 1'h0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, other_channel_irqs = 32'ha0000000, reg_rdata, fetch_address, fetch_next_address;
	logic fetch_request, fetch_done, fetch_irq_on_block_done, transfer_go, transfer_last, write_issued;
	logic write_response, channel_reset_pulse, irq, cfg_irq = 1'h0, cfg_hold = 1'h0;
	logic [3:0] bus_priority;
	logic [31:0] cfg_next = 32'h0;
	logic [5:0] cfg_beats = 6'h04;
	int n_mismatch = 0, checks = 0, cycles = 0;
	always #50 clk = ~clk;
	dma_channel_control_status dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .debug_halt(debug_halt),
		.peripheral_urgent(peripheral_urgent), .other_channel_irqs(other_channel_irqs),
		.fetch_request(fetch_request), .fetch_address(fetch_address), .fetch_done(fetch_done),
		.fetch_next_address(fetch_next_address), .fetch_irq_on_block_done(fetch_irq_on_block_done),
		.transfer_go(transfer_go), .transfer_last(transfer_last), .write_issued(write_issued),
		.write_response(write_response), .bus_priority(bus_priority),
		.channel_reset_pulse(channel_reset_pulse), .irq(irq));
	desc_partner far (.clk(clk), .rst(rst), .fetch_request(fetch_request), .transfer_go(transfer_go),
		.cfg_next(cfg_next), .cfg_irq(cfg_irq), .cfg_beats(cfg_beats), .cfg_hold(cfg_hold),
		.fetch_done(fetch_done), .fetch_next_address(fetch_next_address),
		.fetch_irq_on_block_done(fetch_irq_on_block_done), .transfer_last(transfer_last),
		.write_issued(write_issued), .write_response(write_response));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] e, input string m);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		#1 chk(reg_rdata & mask, e, m);
	endtask
	task automatic wait_hi(input bit fetch);
		int i;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clk);
			#1;
			if ((fetch ? fetch_request : transfer_go) === 1'h1)
				break;
		end
		chk(32'(i < 200), 32'h1, "wait");
	endtask
	task automatic run(input logic [31:0] ctrl);
		wr(DA, 32'h100);
		wr(CS, ctrl);
		repeat (40) @(posedge clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_map;
		rchk(CS, 32'hffffffff, 32'h10, "ctrl");
		rchk(`OFS_CHAN_ENABLES, 32'hffffffff, `ENABLES_RESET, "enables");
		rchk(12'h100, 32'hffffffff, 32'h0, "unmapped");
		rchk(`OFS_IRQ_SUMMARY, 32'hffffffff, 32'ha0000000, "summary");
		wr(`OFS_CHAN_ENABLES, 32'h0);
		run(32'h1);
		chk({31'h0, fetch_request | transfer_go}, 32'h0, "disabled");
		wr(CS, 32'h80000000);
		wr(`OFS_CHAN_ENABLES, 32'h1);
		$display("test map done");
	endtask
	task automatic t_prio;
		wr(CS, 32'h6f570000);
		rchk(CS, 32'hffffffff, 32'h20570010, "fields");
		@(posedge clk);
		peripheral_urgent <= 1'h0;
		@(posedge clk);
		#1 chk({28'h0, bus_priority}, 32'h7, "normal");
		@(posedge clk);
		peripheral_urgent <= 1'h1;
		@(posedge clk);
		#1 chk({28'h0, bus_priority}, 32'h5, "urgent");
		$display("test prio done");
	endtask
	task automatic t_irq;
		cfg_irq = 1'h1;
		run(32'h1);
		rchk(CS, 32'hffffffff, 32'h16, "flags");
		chk({31'h0, irq}, 32'h0, "masked");
		wr(`OFS_IRQ_MASK, 32'h6);
		#1 chk({31'h0, irq}, 32'h1, "irq");
		rchk(`OFS_IRQ_SUMMARY, 32'hffffffff, 32'ha0000001, "summary");
		cfg_irq = 1'h0;
		run(32'h1);
		rchk(CS, 32'hffffffff, 32'h16, "sticky");
		wr(CS, 32'h6);
		rchk(CS, 32'hffffffff, 32'h10, "cleared");
		chk({31'h0, irq}, 32'h0, "irq off");
		$display("test irq done");
	endtask
	task automatic t_halt;
		@(posedge clk);
		debug_halt <= 1'h1;
		run(32'h1);
		chk({31'h0, transfer_go}, 32'h0, "halted");
		rchk(CS, 32'h13, 32'h11, "paused");
		wr(CS, 32'h20000001);
		repeat (40) @(posedge clk);
		rchk(CS, 32'h3, 32'h2, "ignored");
		debug_halt <= 1'h0;
		wr(CS, 32'h2);
		$display("test halt done");
	endtask
	task automatic t_drain;
		cfg_beats <= 6'h14;
		cfg_next <= 32'h300;
		cfg_hold <= 1'h1;
		run(32'h10000001);
		chk({31'h0, transfer_go}, 32'h0, "stall");
		rchk(CS, 32'h10000053, 32'h10000011, "over");
		cfg_hold = 1'h0;
		wait_hi(1'h0);
		wait_hi(1'h1);
		chk(fetch_address, 32'h300, "next");
		cfg_beats = 6'h0c;
		cfg_next = 32'h0;
		cfg_irq = 1'h1;
		cfg_hold = 1'h1;
		wr(CS, 32'h10000003);
		repeat (40) @(posedge clk);
		rchk(CS, 32'h10000047, 32'h10000040, "draining");
		cfg_hold = 1'h0;
		repeat (40) @(posedge clk);
		rchk(CS, 32'h10000047, 32'h10000006, "drained");
		wr(CS, 32'h6);
		$display("test drain done");
	endtask
	task automatic t_abort;
		cfg_beats <= 6'h3f;
		cfg_next <= 32'h200;
		wr(DA, 32'h100);
		wr(CS, 32'h1);
		wait_hi(1'h0);
		wr(CS, 32'h40000001);
		wait_hi(1'h1);
		chk(fetch_address, 32'h200, "resume");
		rchk(CS, 32'h40000000, 32'h0, "abandon");
		wr(CS, 32'h80000000);
		#1 chk({31'h0, channel_reset_pulse}, 32'h1, "pulse");
		rchk(CS, 32'hffffffff, 32'h10, "reset");
		chk({31'h0, channel_reset_pulse}, 32'h0, "pulse end");
		chk({31'h0, fetch_request | transfer_go}, 32'h0, "stopped");
		$display("test abort done");
	endtask
	// cap well above the few hundred cycles the scenarios need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		t_map();
		t_prio();
		t_irq();
		t_halt();
		t_drain();
		t_abort();
		end_sim();
	end
endmodule

// *** verilog/dma_channel_control_status.sv ***
`timescale 1ns/10ps
`include "dma_chan_defs.svh"
// Behaviour
// [R1] writing one to bit 31 resets the channel except enables and irq mask; self-clears, reads zero
// [R2] writing one to bit 30 abandons the current descriptor; self-clears
// [R3] after abandon the channel fetches the next descriptor and carries on
// [R4] ignore-halt bit 29 keeps the channel running under debug halt
// [R5] drain mode bit 28 tallies writes issued minus responses returned
// [R6] in drain mode, completion waits for the last write response
// [R7] while draining, next address loads but its fetch waits for drain end
// [R8] while draining, a zero next address clears the active indication
// [R9] in drain mode, done and pending flags wait for the last response
// [R10] in drain mode, issuing pauses while more than 13 writes outstanding
// [R11] bits 23:20 give bus priority when the peripheral is urgent
// [R12] word at 0xfe0 reports interrupt status of every channel
// [R13] word at 0xff0 holds per-channel enables; channel runs only if enabled
// [R14] bits 19:16 give bus priority when the peripheral is not urgent
// [R15] bit 1 set when a descriptor completes; write one to clear
// [R16] bit 2 set on completion with irq option; sticky until written one
// [R17] status bit 4 reads one whenever paused, including over the write limit
// [R18] control word reads zero at reset, abandon and reserved bits
module dma_channel_control_status
	import dma_chan_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic debug_halt,
	input wire logic peripheral_urgent,
	input wire logic [31:0] other_channel_irqs,
	output logic fetch_request,
	output logic [31:0] fetch_address,
	input wire logic fetch_done,
	input wire logic [31:0] fetch_next_address,
	input wire logic fetch_irq_on_block_done,
	output logic transfer_go,
	input wire logic transfer_last,
	input wire logic write_issued,
	input wire logic write_response,
	output logic [3:0] bus_priority,
	output logic channel_reset_pulse,
	output logic irq
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed
	{
		chan_state_t state;
		logic active;
		logic ignore_halt;
		logic drain_writes;
		logic [3:0] urgent_prio;
		logic [3:0] normal_prio;
		logic [31:0] desc_addr;
		logic [31:0] next_addr;
		logic irq_on_block_done;
		logic [31:0] enables;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
		logic chan_reset;
	} regs_t;
	regs_t cur;
	regs_t next_cur;

	logic wr_ctrl;
	logic do_reset;
	logic do_abandon;
	logic halted;
	logic paused;
	logic tally_over;
	logic [4:0] tally_count;
	logic done_flag;
	logic irq_flag;
	logic set_done;
	logic set_irq;
	logic tally_empty;

	assign wr_ctrl = reg_write && reg_addr == `OFS_CTRL_STATUS;
	assign do_reset = wr_ctrl && reg_wdata[`BIT_CHAN_RESET]; // [R1]
	assign do_abandon = wr_ctrl && reg_wdata[`BIT_ABANDON] && !do_reset; // [R2]
	assign halted = debug_halt && !cur.ignore_halt; // [R4]
	assign tally_empty = tally_count == 5'h00;

	// paused: inactive, disabled, halted or too many writes outstanding
	assign paused = !cur.active || !cur.enables[`THIS_CHANNEL] || halted
		|| (cur.drain_writes && tally_over); // [R17]

	// ****************************************
	// sub-blocks
	// ****************************************
	write_tally u_tally
	(
		.clk(clk),
		.rst(rst),
		.clear(cur.chan_reset),
		.enable(cur.drain_writes), // [R5]
		.write_issued(write_issued),
		.write_response(write_response),
		.count(tally_count),
		.over_limit(tally_over)
	);

	irq_status u_flags
	(
		.clk(clk),
		.rst(rst || cur.chan_reset),
		.set_done(set_done),
		.set_irq(set_irq),
		.clear_done(wr_ctrl && reg_wdata[`BIT_BLOCK_DONE]),
		.clear_irq(wr_ctrl && reg_wdata[`BIT_IRQ_PENDING]),
		.done_flag(done_flag),
		.irq_flag(irq_flag)
	);

	// completion flags rise when the done state is left
	assign set_done = cur.state == ST_DONE; // [R9]
	assign set_irq = cur.state == ST_DONE && cur.irq_on_block_done; // [R16]

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_cur = cur;
		next_cur.chan_reset = do_reset;
		next_cur.rdata = 32'h00000000;
		if (reg_write)
		begin
			unique case (reg_addr)
				`OFS_CTRL_STATUS:
				begin
					next_cur.active = reg_wdata[`BIT_ACTIVE];
					next_cur.ignore_halt = reg_wdata[`BIT_IGNORE_HALT];
					next_cur.drain_writes = reg_wdata[`BIT_DRAIN_WRITES];
					next_cur.urgent_prio = reg_wdata[`URGENT_PRIO_HI:`URGENT_PRIO_LO];
					next_cur.normal_prio = reg_wdata[`NORMAL_PRIO_HI:`NORMAL_PRIO_LO];
				end
				`OFS_DESC_ADDR: next_cur.desc_addr = reg_wdata;
				`OFS_IRQ_MASK: next_cur.irq_mask = reg_wdata[2:1];
				`OFS_CHAN_ENABLES: next_cur.enables = reg_wdata; // [R13]
				default: ;
			endcase
		end
		if (reg_read)
		begin
			unique case (reg_addr)
				`OFS_CTRL_STATUS:
				begin
					// self-clearing and reserved bits read zero
					next_cur.rdata = 32'h00000000; // [R18]
					next_cur.rdata[`BIT_IGNORE_HALT] = cur.ignore_halt;
					next_cur.rdata[`BIT_DRAIN_WRITES] = cur.drain_writes;
					next_cur.rdata[`URGENT_PRIO_HI:`URGENT_PRIO_LO] = cur.urgent_prio;
					next_cur.rdata[`NORMAL_PRIO_HI:`NORMAL_PRIO_LO] = cur.normal_prio;
					next_cur.rdata[`BIT_WAIT_WRITES] = cur.state == ST_DRAIN;
					next_cur.rdata[`BIT_PAUSED] = paused; // [R17]
					next_cur.rdata[`BIT_IRQ_PENDING] = irq_flag;
					next_cur.rdata[`BIT_BLOCK_DONE] = done_flag;
					next_cur.rdata[`BIT_ACTIVE] = cur.active;
				end
				`OFS_DESC_ADDR: next_cur.rdata = cur.desc_addr;
				`OFS_IRQ_MASK: next_cur.rdata = {29'h0, cur.irq_mask, 1'b0};
				`OFS_IRQ_SUMMARY: next_cur.rdata = {other_channel_irqs[31:1], irq_flag}; // [R12]
				`OFS_CHAN_ENABLES: next_cur.rdata = cur.enables;
				default: next_cur.rdata = 32'h00000000;
			endcase
		end
		unique case (cur.state)
			ST_IDLE:
				if (cur.active && cur.enables[`THIS_CHANNEL] && !halted && cur.desc_addr != 32'h00000000)
					next_cur.state = ST_FETCH;
			ST_FETCH:
				if (fetch_done)
				begin
					next_cur.next_addr = fetch_next_address;
					next_cur.irq_on_block_done = fetch_irq_on_block_done;
					next_cur.state = ST_RUN;
				end
			ST_RUN:
				if (do_abandon)
				begin
					// drop this descriptor, go on with the next one
					next_cur.desc_addr = cur.next_addr; // [R3]
					next_cur.active = cur.next_addr != 32'h00000000;
					next_cur.state = cur.next_addr != 32'h00000000 ? ST_FETCH : ST_IDLE;
				end
				else if (transfer_last && transfer_go)
				begin
					next_cur.desc_addr = cur.next_addr; // [R7]
					if (cur.drain_writes && !tally_empty)
					begin
						if (cur.next_addr == 32'h00000000)
							next_cur.active = 1'b0; // [R8]
						next_cur.state = ST_DRAIN; // [R6]
					end
					else
						next_cur.state = ST_DONE;
				end
			ST_DRAIN:
				if (tally_empty)
					next_cur.state = ST_DONE; // [R6]
			ST_DONE:
			begin
				if (cur.desc_addr == 32'h00000000)
					next_cur.active = 1'b0;
				next_cur.state = cur.desc_addr != 32'h00000000 ? ST_FETCH : ST_IDLE;
			end
			default: next_cur.state = ST_IDLE;
		endcase
		if (do_reset)
		begin
			next_cur = '0;
			next_cur.chan_reset = 1'b1;
			next_cur.enables = cur.enables;
			next_cur.irq_mask = cur.irq_mask;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.enables <= `ENABLES_RESET;
		end
		else
			cur <= next_cur;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = cur.rdata;
	assign fetch_request = cur.state == ST_FETCH; // [R7]
	assign fetch_address = cur.desc_addr;
	assign transfer_go = cur.state == ST_RUN && !paused; // [R10]
	assign bus_priority = peripheral_urgent ? cur.urgent_prio : cur.normal_prio; // [R11] [R14]
	assign channel_reset_pulse = cur.chan_reset; // [R1]
	assign irq = (done_flag && cur.irq_mask[0]) || (irq_flag && cur.irq_mask[1]);

	// ****************************************
	// checks
	// ****************************************
	reset_clears_a: assert property (@(posedge clk) disable iff (rst) do_reset |=> cur.state == ST_IDLE && !cur.active) // [R1]
		else $error("channel reset did not idle the channel");
	abandon_next_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		cur.state == ST_RUN && do_abandon && cur.next_addr != 32'h00000000 |=> fetch_request)
		else $error("abandon did not fetch the next descriptor");
	halt_stall_a: assert property (@(posedge clk) disable iff (rst) debug_halt && !cur.ignore_halt |-> !transfer_go) // [R4]
		else $error("transfer ran under debug halt");
	drain_hold_a: assert property (@(posedge clk) disable iff (rst) cur.state == ST_DRAIN && !tally_empty |=> !set_done) // [R9]
		else $error("completion flagged before writes drained");
	drain_nofetch_a: assert property (@(posedge clk) disable iff (rst) cur.state == ST_DRAIN |-> !fetch_request) // [R7]
		else $error("descriptor fetched during drain");
	limit_pause_a: assert property (@(posedge clk) disable iff (rst) cur.drain_writes && tally_count > 5'h0d |-> paused && !transfer_go) // [R10]
		else $error("issue not paused over the write limit");
	prio_select_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		peripheral_urgent |-> bus_priority == cur.urgent_prio)
		else $error("urgent priority not selected");
	ctrl_read_a: assert property (@(posedge clk) disable iff (rst) // [R18]
		reg_read && reg_addr == `OFS_CTRL_STATUS |=> reg_rdata[31:30] == 2'b00 && reg_rdata[27:24] == 4'h0)
		else $error("control read shows reserved bits");
	drain_zero_a: assert property (@(posedge clk) disable iff (rst) // [R8]
		cur.state == ST_RUN && !do_abandon && !do_reset && transfer_last && transfer_go && cur.drain_writes && !tally_empty
		&& cur.next_addr == 32'h00000000 |=> !cur.active)
		else $error("active kept with zero next address");
	reset_selfclear_a: assert property (@(posedge clk) disable iff (rst) // [R1]
		cur.chan_reset && !do_reset |=> !cur.chan_reset)
		else $error("channel reset bit did not self clear");
	abandon_last_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		cur.state == ST_RUN && do_abandon && cur.next_addr == 32'h00000000 |=> cur.state == ST_IDLE && !cur.active)
		else $error("abandon of the last descriptor left the channel busy");
	halt_ignored_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		debug_halt && cur.ignore_halt && cur.state == ST_RUN && cur.active && cur.enables[`THIS_CHANNEL] && !(cur.drain_writes && tally_over) |-> transfer_go)
		else $error("channel stopped under ignored halt");
	tally_count_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		!cur.chan_reset && cur.drain_writes && write_issued && !write_response |=> tally_count == $past(tally_count) + 5'h01)
		else $error("issued write not counted");
	tally_idle_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		!cur.drain_writes |=> tally_count == 5'h00)
		else $error("write tally counting outside drain mode");
	drain_finish_a: assert property (@(posedge clk) disable iff (rst) // [R6]
		cur.state == ST_DRAIN && tally_empty && !do_reset |=> cur.state == ST_DONE)
		else $error("drain did not finish after last response");
	drain_flags_a: assert property (@(posedge clk) disable iff (rst) // [R9]
		cur.state == ST_DRAIN |-> !set_done && !set_irq)
		else $error("flags set while writes outstanding");
	summary_own_a: assert property (@(posedge clk) disable iff (rst) // [R12]
		reg_read && reg_addr == `OFS_IRQ_SUMMARY && irq_flag |=> reg_rdata[0])
		else $error("summary misses this channel's pending flag");
	enable_gate_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		!cur.enables[`THIS_CHANNEL] |-> !transfer_go)
		else $error("disabled channel issued a transfer");
	prio_normal_a: assert property (@(posedge clk) disable iff (rst) // [R14]
		!peripheral_urgent |-> bus_priority == cur.normal_prio)
		else $error("normal priority not selected");
	paused_read_a: assert property (@(posedge clk) disable iff (rst) // [R17]
		reg_read && reg_addr == `OFS_CTRL_STATUS && cur.drain_writes && tally_over |=> reg_rdata[`BIT_PAUSED])
		else $error("paused bit clear over the write limit");
endmodule

// *** verilog/irq_status.sv ***
`timescale 1ns/10ps
`include "dma_chan_defs.svh"
module irq_status
	import dma_chan_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic set_done,
	input wire logic set_irq,
	input wire logic clear_done,
	input wire logic clear_irq,
	output logic done_flag,
	output logic irq_flag
);
	typedef struct packed
	{
		logic done;
		logic irq;
	} flags_t;
	flags_t cur;
	flags_t next_cur;

	// set wins over a clear in the same cycle
	always_comb
	begin
		next_cur = cur;
		next_cur.done = set_done | (cur.done & ~clear_done); // [R15]
		next_cur.irq = set_irq | (cur.irq & ~clear_irq); // [R16]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign done_flag = cur.done;
	assign irq_flag = cur.irq;

	irq_sticky_a: assert property (@(posedge clk) disable iff (rst) cur.irq && !clear_irq |=> cur.irq) // [R16]
		else $error("pending flag dropped without a clear");
	done_set_a: assert property (@(posedge clk) disable iff (rst) set_done |=> cur.done) // [R15]
		else $error("block done flag not set");
endmodule

// *** verilog/write_tally.sv ***
`timescale 1ns/10ps
`include "dma_chan_defs.svh"
module write_tally
	import dma_chan_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic enable,
	input wire logic write_issued,
	input wire logic write_response,
	output logic [4:0] count,
	output logic over_limit
);
	typedef struct packed
	{
		logic [4:0] count;
	} tally_t;
	tally_t cur;
	tally_t next_cur;

	always_comb
	begin
		next_cur = cur;
		if (clear || !enable)
			next_cur.count = 5'h00;
		else if (write_issued && !write_response)
			next_cur.count = cur.count + 5'h01;
		else if (!write_issued && write_response && cur.count != 5'h00)
			next_cur.count = cur.count - 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign count = cur.count;
	// more than the limit outstanding stalls the issue side
	assign over_limit = cur.count > `MAX_OUTSTANDING;

	tally_bound_a: assert property (@(posedge clk) disable iff (rst) cur.count <= 5'h0f) // [R10]
		else $error("write tally ran past its limit");
endmodule
